// ==== include/serial_port_consts.svh ====
// constants of the serial host control port
`ifndef SERIAL_PORT_CONSTS_SVH
`define SERIAL_PORT_CONSTS_SVH

// fixed upper five bits of the seven-bit slave address
`define SLV_ADDR_TOP 5'h17

// sub-addresses of the core steering registers
`define OFS_WR_MASK 8'hfe
`define OFS_RD_SEL 8'hff

// reset values of the steering registers and the pointer
`define WMASK_RST 4'hf
`define RSEL_RST 4'h1
`define PTR_RST 8'h00

// value written to clear a steering register, and the empty read nibble
`define NIBBLE_CLR 4'h0

// bits per byte on the wire
`define BYTE_BITS 4'h8

// settle time of a stretch, in ns, and the derived count at 50 MHz
`define MCLK_PERIOD_NS 20
`define SETTLE_NS 120
`define SETTLE_CYC 4'((`SETTLE_NS + `MCLK_PERIOD_NS - 1) / `MCLK_PERIOD_NS)

`endif

// ==== include/serial_port_pkg.sv ====
// types shared by the serial host control port
package serial_port_pkg;

	// byte engine states
	typedef enum logic [2:0] {
		ST_IDLE,
		ST_BITS,
		ST_SETTLE,
		ST_ACK,
		ST_TX,
		ST_TXACK,
		ST_IGNORE
	} st_t;

	// meaning of the byte being handled in a stretch
	typedef enum logic [1:0] {
		K_ADDR,
		K_SUB,
		K_DATA,
		K_TXLOAD
	} kind_t;

	// write forwarded to the decoder cores
	typedef struct packed {
		logic stb;
		logic [3:0] en;
		logic [7:0] addr;
		logic [7:0] data;
	} core_wr_t;

	// state of the link-clock side
	typedef struct packed {
		logic [7:0] sh;
	} lnk_state_t;

	// state of the main-clock side
	typedef struct packed {
		st_t st;
		kind_t kind;
		logic rw;
		logic [3:0] bitcnt;
		logic [3:0] cnt;
		logic [7:0] ptr;
		logic [3:0] wmask;
		logic [3:0] rsel;
		logic [3:0] rd_core;
		logic [7:0] txsh;
		logic sda_oe;
		logic scl_oe;
		logic drive_lvl;
		logic busy;
		logic [1:0] pick;
		logic pick_done;
		logic [1:0] strap_s1;
		logic [1:0] strap_s2;
		logic scl_s1;
		logic scl_s2;
		logic scl_p;
		logic sda_s1;
		logic sda_s2;
		logic sda_p;
		logic [7:0] lnk_s1;
		logic [7:0] lnk_s2;
		core_wr_t wr;
	} ctl_state_t;

endpackage : serial_port_pkg

// ==== rtl/serial_host_port.sv ====
// two-wire slave port steering register access to four decoder cores
//
// How it works
// R1 - only a slave: drives data low for ack/read bits, clock only stretched
// R2 - address straps are latched at reset release and kept till next reset
// R3 - address is 10111 then latched hi and lo strap bits
// R4 - works up to 400 kbit/s; master must not clock faster
// R5 - data changes only while clock is low, except start and stop
// R6 - start is data falling with clock high, stop data rising
// R7 - eight bits, msb first, then an ack clocked by the master
// R8 - one write goes to every core enabled in the write mask
// R9 - write mask has one enable bit per core
// R10 - read select picks the core; lowest set bit wins
// R11 - host should set only one read select bit at a time
// R12 - writing either steering register clears the other to zero
// R13 - master writes: start, address+0, sub-address, data bytes, stop
// R14 - address, sub-address and every written data byte are acknowledged
// R15 - read starts with write address, sub-address, then stop
// R16 - after address+1 the port acks then sends bytes on request
// R17 - master acks each read byte but the last, then stops
// R18 - clock is held low while the byte is being processed
// R19 - master not watching stretch pauses between low register accesses
// R20 - master keeps lines static until reset is done
// R21 - register pointer advances after every written data byte and after every read byte the master acks
`timescale 1ns/1ns
`include "serial_port_consts.svh"

module serial_host_port (
	// main clock and reset
	input wire logic mclk_i,
	input wire logic srst_i,
	// link clock: the bus clock line as seen by the shift register
	input wire logic scl_clk_i,
	// bus clock line, open drain
	input wire logic scl_i,
	output logic scl_o,
	output logic scl_oe_o,
	// bus data line, open drain
	input wire logic sda_i,
	output logic sda_o,
	output logic sda_oe_o,
	// address straps
	input wire logic slave_addr_pick_lo_i,
	input wire logic slave_addr_pick_hi_i,
	// write path to the decoder cores
	output serial_port_pkg::core_wr_t core_wr_o,
	// read path from the decoder cores
	output logic [7:0] core_rd_addr_o,
	output logic [3:0] core_rd_sel_o,
	input wire logic [3:0][7:0] core_rdata_i,
	// status
	output logic busy_o
);

	////////////////////////////////////////////////////////////////////////
	// link-clock side

	serial_port_pkg::lnk_state_t lnk_q;
	serial_port_pkg::lnk_state_t lnk_d;

	// shift in one data bit on every clock rise, msb first
	always_comb begin
		lnk_d = lnk_q;
		lnk_d.sh = {lnk_q.sh[6:0], sda_i}; // R7
	end

	// the link clock stops between frames, so this side holds no control
	always_ff @(posedge scl_clk_i) begin
		lnk_q <= lnk_d;
	end

	////////////////////////////////////////////////////////////////////////
	// main-clock side

	serial_port_pkg::ctl_state_t q;
	serial_port_pkg::ctl_state_t d;

	logic scl_rise;
	logic scl_fall;
	logic start_seen;
	logic stop_seen;
	logic [3:0] lo_hot;
	logic [3:0][7:0] sel_data;
	logic [7:0] core_byte;
	logic [7:0] tx_byte;
	logic [7:0] byte_in;
	logic addr_hit;

	// edges of the synchronised lines
	assign scl_rise = q.scl_s2 && !q.scl_p;
	assign scl_fall = !q.scl_s2 && q.scl_p;
	assign start_seen = q.scl_s2 && q.scl_p && q.sda_p && !q.sda_s2; // R6
	assign stop_seen = q.scl_s2 && q.scl_p && !q.sda_p && q.sda_s2; // R6

	// the byte caught on the link side, stable while the clock is held
	// the eight bits cross as a word: no link clock edge arrives while
	// the port holds the clock low, and the settle count outlasts both
	// synchroniser stages, so the word is only read once it is quiet
	assign byte_in = q.lnk_s2;

	// address match against the latched straps
	assign addr_hit = (byte_in[7:1] == {`SLV_ADDR_TOP, q.pick}); // R3

	// lowest set read select bit, and that core's data
	for (genvar i = 0; i < 4; i++) begin : g_core
		assign lo_hot[i] = q.rsel[i]
			&& ((q.rsel & 4'((1 << i) - 1)) == `NIBBLE_CLR); // R10
		assign sel_data[i] = lo_hot[i] ? core_rdata_i[i] : 8'h00;
	end

	// or of the masked core bytes; at most one is non-zero
	always_comb begin
		core_byte = 8'h00;
		for (int k = 0; k < 4; k++) begin
			core_byte = core_byte | sel_data[k];
		end
	end

	// byte answered at the current pointer
	always_comb begin
		if (q.ptr == `OFS_WR_MASK) begin
			tx_byte = {`NIBBLE_CLR, q.wmask};
		end else if (q.ptr == `OFS_RD_SEL) begin
			tx_byte = {`NIBBLE_CLR, q.rsel};
		end else begin
			tx_byte = core_byte; // R10
		end
	end

	// next state of the byte engine and register file
	always_comb begin
		d = q;
		// two flip-flop synchronisers for pins and the link byte; many
		// mclk samples per half bit at the top bit rate leave ample margin
		d.scl_s1 = scl_i; // R4
		d.scl_s2 = q.scl_s1;
		d.scl_p = q.scl_s2;
		d.sda_s1 = sda_i;
		d.sda_s2 = q.sda_s1;
		d.sda_p = q.sda_s2;
		d.strap_s1 = {slave_addr_pick_hi_i, slave_addr_pick_lo_i};
		d.strap_s2 = q.strap_s1;
		d.lnk_s1 = lnk_q.sh;
		d.lnk_s2 = q.lnk_s1;
		d.wr.stb = 1'b0;
		d.rd_core = lo_hot;
		d.drive_lvl = 1'b0; // R1
		d.busy = (q.st != serial_port_pkg::ST_IDLE)
			&& (q.st != serial_port_pkg::ST_IGNORE);

		// straps are taken once, in the first cycle after reset release
		// a strap that moves later does not change the address
		if (!q.pick_done) begin
			d.pick = q.strap_s2; // R2
			d.pick_done = 1'b1; // R2
		end

		// the clock is only held inside a settle period
		if (q.st != serial_port_pkg::ST_SETTLE) begin
			d.scl_oe = 1'b0; // R18
		end

		// start and stop override every state
		if (start_seen) begin
			d.st = serial_port_pkg::ST_BITS; // R6
			d.kind = serial_port_pkg::K_ADDR;
			d.bitcnt = 4'h0;
			d.sda_oe = 1'b0;
		end else if (stop_seen) begin
			d.st = serial_port_pkg::ST_IDLE; // R6
			d.sda_oe = 1'b0;
		end else begin
			case (q.st)
				serial_port_pkg::ST_IDLE: begin
					d.sda_oe = 1'b0;
				end

				// count master bits; hold the clock after the eighth
				serial_port_pkg::ST_BITS: begin
					if (scl_rise) begin
						d.bitcnt = q.bitcnt + 4'h1; // R7
					end
					if (scl_fall && (q.bitcnt == `BYTE_BITS)) begin
						d.st = serial_port_pkg::ST_SETTLE; // R18
						d.scl_oe = 1'b1; // R18
						d.cnt = 4'h0;
					end
				end

				// clock held low; the link byte settles, then is used
				// the master cannot clock the next bit before the ack
				// level or the first read bit is on the line
				serial_port_pkg::ST_SETTLE: begin
					d.cnt = q.cnt + 4'h1;
					if (q.cnt == `SETTLE_CYC) begin
						case (q.kind)
							serial_port_pkg::K_ADDR: begin
								if (addr_hit) begin
									d.rw = byte_in[0]; // R16
									d.sda_oe = 1'b1; // R14
									d.kind = serial_port_pkg::K_SUB;
									d.st = serial_port_pkg::ST_ACK;
								end else begin
									d.st = serial_port_pkg::ST_IGNORE;
								end
							end
							serial_port_pkg::K_SUB: begin
								d.ptr = byte_in;
								d.sda_oe = 1'b1; // R14
								d.kind = serial_port_pkg::K_DATA;
								d.st = serial_port_pkg::ST_ACK;
							end
							serial_port_pkg::K_DATA: begin
								if (q.ptr == `OFS_WR_MASK) begin
									d.wmask = byte_in[3:0]; // R9
									d.rsel = `NIBBLE_CLR; // R12
								end else if (q.ptr == `OFS_RD_SEL) begin
									d.rsel = byte_in[3:0]; // R10
									d.wmask = `NIBBLE_CLR; // R12
								end else begin
									d.wr.stb = 1'b1; // R8
									d.wr.en = q.wmask; // R9
									d.wr.addr = q.ptr;
									d.wr.data = byte_in;
								end
								d.ptr = q.ptr + 8'h01; // R21
								d.sda_oe = 1'b1; // R14
								d.st = serial_port_pkg::ST_ACK;
							end
							serial_port_pkg::K_TXLOAD: begin
								d.txsh = tx_byte; // R16
								d.sda_oe = !tx_byte[7]; // R7
								d.bitcnt = 4'h0;
								d.st = serial_port_pkg::ST_TX;
							end
							default: begin
								d.st = serial_port_pkg::ST_IGNORE;
							end
						endcase
					end
				end

				// ack bit: data held until the ack clock falls
				// a write goes back to counting bits; a read reloads
				serial_port_pkg::ST_ACK: begin
					if (scl_fall) begin
						d.sda_oe = 1'b0; // R5
						if (q.rw) begin
							d.st = serial_port_pkg::ST_SETTLE; // R18
							d.kind = serial_port_pkg::K_TXLOAD;
							d.scl_oe = 1'b1; // R18
							d.cnt = 4'h0;
						end else begin
							d.st = serial_port_pkg::ST_BITS;
							d.bitcnt = 4'h0;
						end
					end
				end

				// send a byte; the next bit goes out after each fall
				serial_port_pkg::ST_TX: begin
					if (scl_rise) begin
						d.bitcnt = q.bitcnt + 4'h1;
					end
					if (scl_fall) begin
						if (q.bitcnt == `BYTE_BITS) begin
							d.sda_oe = 1'b0;
							d.st = serial_port_pkg::ST_TXACK;
						end else begin
							d.txsh = {q.txsh[6:0], 1'b0};
							d.sda_oe = !q.txsh[6]; // R5
						end
					end
				end

				// master ack continues the read, no ack ends it
				// the ack level is taken at the synced rise, when it is steady
				serial_port_pkg::ST_TXACK: begin
					if (scl_rise) begin
						if (!q.sda_s2) begin
							d.ptr = q.ptr + 8'h01; // R21
							d.st = serial_port_pkg::ST_ACK;
						end else begin
							d.st = serial_port_pkg::ST_IGNORE; // R17
						end
					end
				end

				// not addressed or read ended: wait for start or stop
				serial_port_pkg::ST_IGNORE: begin
					d.sda_oe = 1'b0;
				end

				default: begin
					d.st = serial_port_pkg::ST_IDLE;
					d.sda_oe = 1'b0;
				end
			endcase
		end
	end

	// register the state; the pin and strap synchronisers keep running through reset
	// so that the first cycle after release already sees settled straps
	// and the true idle levels of both lines; scl_p is cleared, so a clock rise shows then
	always_ff @(posedge mclk_i) begin
		if (srst_i) begin
			q <= '0;
			q.wmask <= `WMASK_RST;
			q.rsel <= `RSEL_RST;
			q.ptr <= `PTR_RST;
			q.scl_s1 <= d.scl_s1;
			q.scl_s2 <= d.scl_s2;
			q.sda_s1 <= d.sda_s1;
			q.sda_s2 <= d.sda_s2;
			q.strap_s1 <= d.strap_s1;
			q.strap_s2 <= d.strap_s2;
		end else begin
			q <= d;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// outputs, all straight from flip-flops
	// the open-drain levels are constant low; the enables do the work

	assign scl_o = q.drive_lvl;
	assign scl_oe_o = q.scl_oe;
	assign sda_o = q.drive_lvl;
	assign sda_oe_o = q.sda_oe;
	assign core_wr_o = q.wr;
	assign core_rd_addr_o = q.ptr;
	assign core_rd_sel_o = q.rd_core;
	assign busy_o = q.busy;

endmodule : serial_host_port

// ==== verification/serial_host_port_properties.sv ====
// port assertions of the serial host control port
`timescale 1ns/1ns

module serial_host_port_properties (
	// clock and reset
	input wire logic mclk_i,
	input wire logic srst_i,
	// bus side
	input wire logic scl_i,
	input wire logic scl_o,
	input wire logic scl_oe_o,
	input wire logic sda_o,
	input wire logic sda_oe_o,
	// core side
	input wire serial_port_pkg::core_wr_t core_wr_o,
	input wire logic [7:0] core_rd_addr_o,
	input wire logic [3:0] core_rd_sel_o
);
	default clocking @(posedge mclk_i); endclocking
	default disable iff (srst_i);

	// open-drain levels and stretching
	AST_SCL_LOW_ONLY: assert property (scl_o == 1'b0)
		else $error("clock line driven high");
	AST_SDA_LOW_ONLY: assert property (sda_o == 1'b0)
		else $error("data line driven high");
	AST_STRETCH_LEN: assert property ($rose(scl_oe_o) |->
		scl_oe_o [*8] ##1 !scl_oe_o) else $error("stretch length off");
	AST_SDA_CLK_LOW: assert property ($changed(sda_oe_o) |-> !scl_i)
		else $error("data changed with clock high");

	// core write path and steering
	AST_STB_IN_STRETCH: assert property (core_wr_o.stb |-> scl_oe_o)
		else $error("core write outside stretch");
	AST_STB_PULSE: assert property (core_wr_o.stb |=> !core_wr_o.stb)
		else $error("core strobe too long");
	AST_LOCAL_REGS: assert property (core_wr_o.stb |->
		core_wr_o.addr < 8'hfe) else $error("steering write forwarded");
	AST_RD_ONEHOT: assert property ($onehot0(core_rd_sel_o))
		else $error("read select not one-hot");
	AST_PTR_INC: assert property (core_wr_o.stb |->
		##[1:4] core_rd_addr_o == core_wr_o.addr + 8'h01)
		else $error("pointer not advanced");
endmodule : serial_host_port_properties

bind serial_host_port serial_host_port_properties i_props (
	.mclk_i(mclk_i), .srst_i(srst_i), .scl_i(scl_i), .scl_o(scl_o),
	.scl_oe_o(scl_oe_o), .sda_o(sda_o), .sda_oe_o(sda_oe_o),
	.core_wr_o(core_wr_o), .core_rd_addr_o(core_rd_addr_o),
	.core_rd_sel_o(core_rd_sel_o));

// ==== verification/bus_master_model.sv ====
// two-wire bus master model
`timescale 1ns/1ns

module bus_master_model (
	// resolved bus lines
	input wire logic scl_i,
	input wire logic sda_i,
	// pull-low requests
	output logic scl_low_o,
	output logic sda_low_o
);
	localparam int HALF_NS = 1250;
	int wait_n;

	// lines idle high from time zero
	initial begin
		scl_low_o = 1'b0;
		sda_low_o = 1'b0;
	end

	////////////////////////////////
	// one bit, waiting out a held-low clock
	task bit_io(input logic b, output logic r);
		sda_low_o = ~b;
		#(HALF_NS / 2);
		scl_low_o = 1'b0;
		wait_n = 0;
		// the clock is watched, so no fixed pause is needed
		while (scl_i !== 1'b1 && wait_n < 400) begin
			#20;
			wait_n++;
		end
		if (wait_n >= 400) begin
			serial_host_port_tb.num_errors++;
		end
		#HALF_NS;
		r = sda_i;
		scl_low_o = 1'b1;
		#(HALF_NS / 2);
	endtask : bit_io

	// eight bits msb first, then the acknowledge slot
	task byte_io(input logic [8:0] tx, output logic [8:0] rx);
		for (int i = 8; i >= 0; i--) begin
			bit_io(tx[i], rx[i]);
		end
	endtask : byte_io

	// start from an idle bus
	task start_cond();
		sda_low_o = 1'b1;
		#HALF_NS;
		scl_low_o = 1'b1;
		#(HALF_NS / 2);
	endtask : start_cond

	// stop after a byte
	task stop_cond();
		sda_low_o = 1'b1;
		#(HALF_NS / 2);
		scl_low_o = 1'b0;
		#HALF_NS;
		sda_low_o = 1'b0;
		#HALF_NS;
	endtask : stop_cond
endmodule : bus_master_model

// ==== verification/serial_host_port_tb.sv ====
// self-checking bench of the serial host control port
`timescale 1ns/1ns

module serial_host_port_tb;
	logic mclk, srst, pick_lo, pick_hi, scl_oe, sda_oe, m_scl, m_sda;
	logic scl_w, sda_w, busy;
	serial_port_pkg::core_wr_t wr;
	logic [7:0] rd_addr;
	logic [3:0] rd_sel;
	logic [3:0][7:0] rdata;
	logic [8:0] rx;
	logic [19:0] wq[$];
	int num_errors = 0;
	int num_checks = 0;

	// pull-ups resolve both open-drain lines
	assign scl_w = ~(scl_oe | m_scl);
	assign sda_w = ~(sda_oe | m_sda);

	serial_host_port i_serial_host_port (.mclk_i(mclk), .srst_i(srst),
		.scl_clk_i(scl_w), .scl_i(scl_w), .scl_o(), .scl_oe_o(scl_oe),
		.sda_i(sda_w), .sda_o(), .sda_oe_o(sda_oe),
		.slave_addr_pick_lo_i(pick_lo), .slave_addr_pick_hi_i(pick_hi),
		.core_wr_o(wr), .core_rd_addr_o(rd_addr), .core_rd_sel_o(rd_sel),
		.core_rdata_i(rdata), .busy_o(busy));

	bus_master_model i_bus_master_model (.scl_i(scl_w), .sda_i(sda_w),
		.scl_low_o(m_scl), .sda_low_o(m_sda));

	// main clock
	initial begin
		mclk = 1'b0;
		forever #10 mclk = ~mclk;
	end

	// cores return address plus 0x40 per core index; writes are logged
	always @(posedge mclk) begin
		for (int k = 0; k < 4; k++) begin
			rdata[k] <= rd_addr + 8'(k * 64);
		end
		if (wr.stb === 1'b1) begin
			wq.push_back({wr.en, wr.addr, wr.data});
		end
	end

	////////////////////////////////
	// compare and report
	task cmp(input logic [19:0] got, input logic [19:0] exp);
		num_checks++;
		if (got !== exp) begin
			num_errors++;
			$display("wrong value at %0t: got %h expected %h", $time, got, exp);
		end
	endtask : cmp

	// bus write of a byte list, every ack level checked against the one given
	task bwr(input logic [7:0] b[$], input logic nak);
		i_bus_master_model.start_cond();
		foreach (b[i]) begin
			i_bus_master_model.byte_io({b[i], 1'b1}, rx);
			cmp(20'(rx[0]), 20'(nak));
		end
		i_bus_master_model.stop_cond();
	endtask : bwr

	// two-phase read, last byte not acknowledged
	task brd(input logic [7:0] sub, input logic [7:0] e[$]);
		bwr({8'hbc, sub}, 1'b0);
		i_bus_master_model.start_cond();
		i_bus_master_model.byte_io({8'hbd, 1'b1}, rx);
		cmp(20'(rx[0]), 20'h0_0000);
		foreach (e[i]) begin
			i_bus_master_model.byte_io({8'hff, i == e.size() - 1}, rx);
			cmp(20'(rx[8:1]), 20'(e[i]));
		end
		i_bus_master_model.stop_cond();
	endtask : brd

	// logged core writes against the expected list
	task cwr(input logic [19:0] e[$]);
		cmp(20'(wq.size()), 20'(e.size()));
		foreach (e[i]) begin
			cmp(wq[i], e[i]);
		end
		wq.delete();
	endtask : cwr

	task complete_run();
		$display("checks %0d errors %0d", num_checks, num_errors);
		if (num_errors == 0 && num_checks > 0)
			$display("SIMULATION PASSED");
		else
			$display("SIMULATION FAILED");
		$finish;
	endtask : complete_run

	// watchdog
	initial begin
		#1200000;
		num_errors++;
		complete_run();
	end

	// test sequence
	initial begin
		srst = 1'b1;
		pick_lo = 1'b0;
		pick_hi = 1'b1;
		repeat (3) @(posedge mclk);
		srst <= 1'b0;
		repeat (4) @(posedge mclk);
		cmp(20'(rd_sel), 20'h0_0001);
		pick_hi <= 1'b0;
		bwr({8'hbe}, 1'b1);
		bwr({8'hb8}, 1'b1);
		$display("test address done");
		i_bus_master_model.start_cond();
		cmp(20'(busy), 20'h0_0001);
		i_bus_master_model.stop_cond();
		cmp(20'(busy), 20'h0_0000);
		bwr({8'hbc, 8'h10, 8'ha5, 8'h5a}, 1'b0);
		cwr({20'hf_10a5, 20'hf_115a});
		bwr({8'hbc, 8'hfe, 8'h05}, 1'b0);
		cmp(20'(rd_sel), 20'h0_0000);
		bwr({8'hbc, 8'h20, 8'h33}, 1'b0);
		cwr({20'h5_2033});
		bwr({8'hbc, 8'hff, 8'h06}, 1'b0);
		cmp(20'(rd_sel), 20'h0_0002);
		bwr({8'hbc, 8'h21, 8'h44}, 1'b0);
		cwr({20'h0_2144});
		bwr({8'hbc, 8'hff, 8'h02}, 1'b0);
		cmp(20'(rd_sel), 20'h0_0002);
		$display("test steering done");
		brd(8'h30, {8'h70, 8'h71});
		brd(8'hfe, {8'h00, 8'h02});
		$display("test read done");
		complete_run();
	end
endmodule : serial_host_port_tb
